// ### src/oag_top.sv
/*
  Operand address generator and instruction class decoder: checks the
  operation against the addressing mode, gives the length, the operand
  address, the next program counter and the multiply result.
  Assumes the fetch unit presents the decoded operation, the mode and the
  bytes after the opcode together with a one-cycle start pulse.
*/
`timescale 1ns/100ps
// Summary of operation
// - Sixteen-bit offset mode: address is index plus sixteen-bit offset.
// - First byte after opcode is offset high half, second is low.
// - Sixteen-bit offset instructions are three bytes and reach all memory.
// - Sixteen-bit offset only for register/memory ops and jumps, not modify ops.
// - All indexed-list ops accept no-offset and eight-bit offset forms.
// - Relative mode only for branches and bit test branches.
// - Taken branch: program counter plus sign-extended offset byte.
// - Branch not taken: continue at the following instruction.
// - Offset is signed, measured from the next instruction address.
// - Full set of branch conditions including bit tests and subroutine.
// - Multiply accumulator by index; high byte to index, low to accumulator.
// - One operand from accumulator or index, other from memory.
// - Register/memory ops accept direct, extended and indexed modes; immediate for all but stores.
// - Register/memory class: loads, stores, arithmetic, logic, compares, bit test; multiply is not in it.
// - No-offset indexed: index is low byte, high byte zero.
// - Eight-bit offset indexed: index plus byte, up to location 510.
module oag_top
  import oag_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire oag_pkg::oag_op_t i_op,
  input wire oag_pkg::oag_mode_t i_mode,
  input wire oag_pkg::oag_cond_t i_cond,
  input wire logic [7:0] i_byte1,
  input wire logic [7:0] i_byte2,
  input wire logic [15:0] i_pc,
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_index,
  input wire logic i_flag_carry,
  input wire logic i_flag_zero,
  input wire logic i_flag_half,
  input wire logic i_flag_negative,
  input wire logic i_flag_mask,
  input wire logic i_mem_bit,
  input wire logic i_irq_pin,
  output logic o_done,
  output logic o_illegal,
  output logic [1:0] o_length,
  output logic [15:0] o_ea,
  output logic o_mem_read,
  output logic o_mem_write,
  output logic o_use_index,
  output logic o_imm_valid,
  output logic [7:0] o_imm_data,
  output logic o_branch_taken,
  output logic [15:0] o_pc_next,
  output logic o_mul_done,
  output logic [7:0] o_mul_acc,
  output logic [7:0] o_mul_index
);
  logic irq_meta_q;
  logic irq_sync_q;
  logic done_q;
  logic illegal_q;
  logic [1:0] length_q;
  logic [15:0] ea_q;
  logic mem_read_q;
  logic mem_write_q;
  logic use_index_q;
  logic imm_valid_q;
  logic [7:0] imm_q;
  logic taken_q;
  logic [15:0] pc_next_q;

  // Instruction class
  wire logic is_mul = (i_op == OAG_UNSIGNED_MULTIPLY);
  wire logic is_regmem = (i_op <= OAG_BIT_TEST);
  wire logic is_store = (i_op == OAG_STORE_ACCUMULATOR) || (i_op == OAG_STORE_INDEX);
  wire logic is_jump = (i_op == OAG_JUMP_UNCONDITIONAL) || (i_op == OAG_JUMP_TO_SUBROUTINE);
  wire logic is_modify = (i_op >= OAG_SHIFT_LEFT) && (i_op <= OAG_TEST_NEGATIVE_ZERO);
  wire logic is_branch = (i_op >= OAG_BRANCH_CONDITIONAL);
  wire logic is_bit_branch = (i_op >= OAG_BRANCH_IF_MEMORY_BIT_SET);
  wire logic mem_mode = (i_mode != OAG_MODE_INHERENT) && (i_mode != OAG_MODE_IMMEDIATE);

  // Mode legality
  wire logic ok_inherent = is_modify || is_mul;
  wire logic ok_immediate = is_regmem && !is_store;
  wire logic ok_direct = is_regmem || is_jump || is_modify;
  wire logic ok_extended = is_regmem || is_jump;
  wire logic ok_index_short = is_regmem || is_jump || is_modify;
  wire logic ok_index_long = is_regmem || is_jump;
  wire logic ok_relative = is_branch;
  wire logic legal =
    (i_mode == OAG_MODE_INHERENT) ? ok_inherent :
    (i_mode == OAG_MODE_IMMEDIATE) ? ok_immediate :
    (i_mode == OAG_MODE_DIRECT) ? ok_direct :
    (i_mode == OAG_MODE_EXTENDED) ? ok_extended :
    (i_mode == OAG_MODE_INDEX_NO_OFFSET) ? ok_index_short :
    (i_mode == OAG_MODE_INDEX_OFFSET8) ? ok_index_short :
    (i_mode == OAG_MODE_INDEX_OFFSET16) ? ok_index_long :
    ok_relative;

  // Instruction length
  wire logic [1:0] length_d =
    ((i_mode == OAG_MODE_INHERENT) || (i_mode == OAG_MODE_INDEX_NO_OFFSET)) ? OAG_LEN_ONE :
    ((i_mode == OAG_MODE_EXTENDED) || (i_mode == OAG_MODE_INDEX_OFFSET16)) ? OAG_LEN_THREE :
    ((i_mode == OAG_MODE_RELATIVE) && is_bit_branch) ? OAG_LEN_THREE :
    OAG_LEN_TWO;

  // Operand address
  wire logic [15:0] offset16 = {i_byte1, i_byte2};
  wire logic [15:0] ea_index0 = {OAG_PAGE_ZERO_HIGH, i_index};
  wire logic [8:0] sum9 = {1'b0, i_byte1} + {1'b0, i_index};
  wire logic [15:0] ea_index8 = {7'h00, sum9};
  wire logic [16:0] sum17 = {1'b0, offset16} + {9'h000, i_index};
  wire logic [15:0] ea_index16 = sum17[15:0];
  wire logic [15:0] ea_direct = {OAG_PAGE_ZERO_HIGH, i_byte1};
  wire logic [15:0] ea_d =
    (i_mode == OAG_MODE_DIRECT) ? ea_direct :
    (i_mode == OAG_MODE_EXTENDED) ? offset16 :
    (i_mode == OAG_MODE_INDEX_NO_OFFSET) ? ea_index0 :
    (i_mode == OAG_MODE_INDEX_OFFSET8) ? ea_index8 :
    (i_mode == OAG_MODE_INDEX_OFFSET16) ? ea_index16 :
    ((i_mode == OAG_MODE_RELATIVE) && is_bit_branch) ? ea_direct :
    OAG_WORD_RESET;

  // Branch condition and target
  wire logic cond_true =
    (i_cond == OAG_COND_ALWAYS) ? 1'b1 :
    (i_cond == OAG_COND_NEVER) ? 1'b0 :
    (i_cond == OAG_COND_HIGHER) ? !(i_flag_carry || i_flag_zero) :
    (i_cond == OAG_COND_LOWER_OR_SAME) ? (i_flag_carry || i_flag_zero) :
    (i_cond == OAG_COND_CARRY_CLEAR) ? !i_flag_carry :
    (i_cond == OAG_COND_CARRY_SET) ? i_flag_carry :
    (i_cond == OAG_COND_NOT_EQUAL) ? !i_flag_zero :
    (i_cond == OAG_COND_EQUAL) ? i_flag_zero :
    (i_cond == OAG_COND_HALF_CARRY_CLEAR) ? !i_flag_half :
    (i_cond == OAG_COND_HALF_CARRY_SET) ? i_flag_half :
    (i_cond == OAG_COND_PLUS) ? !i_flag_negative :
    (i_cond == OAG_COND_MINUS) ? i_flag_negative :
    (i_cond == OAG_COND_MASK_CLEAR) ? !i_flag_mask :
    (i_cond == OAG_COND_MASK_SET) ? i_flag_mask :
    (i_cond == OAG_COND_IRQ_LINE_LOW) ? !irq_sync_q :
    irq_sync_q;
  wire logic taken_d = legal && (
    ((i_op == OAG_BRANCH_CONDITIONAL) && cond_true) ||
    (i_op == OAG_BRANCH_TO_SUBROUTINE) ||
    ((i_op == OAG_BRANCH_IF_MEMORY_BIT_SET) && i_mem_bit) ||
    ((i_op == OAG_BRANCH_IF_MEMORY_BIT_CLEAR) && !i_mem_bit));
  wire logic [7:0] rel_offset = is_bit_branch ? i_byte2 : i_byte1;
  wire logic [15:0] pc_follow = 16'(i_pc + {14'h0000, length_d});
  wire logic [15:0] pc_target = 16'(pc_follow + {{8{rel_offset[7]}}, rel_offset});
  wire logic [15:0] pc_next_d = taken_d ? pc_target : pc_follow;

  // Operand routing
  wire logic use_index_d = (i_op == OAG_LOAD_INDEX) || (i_op == OAG_STORE_INDEX) ||
    (i_op == OAG_COMPARE_INDEX);
  wire logic mem_read_d = legal && mem_mode && !is_store && !is_jump &&
    (is_regmem || is_modify || is_bit_branch);
  wire logic mem_write_d = legal && mem_mode && is_store;
  wire logic imm_valid_d = legal && (i_mode == OAG_MODE_IMMEDIATE);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      irq_meta_q <= 1'b0;
      irq_sync_q <= 1'b0;
    end
    else
    begin
      irq_meta_q <= i_irq_pin;
      irq_sync_q <= irq_meta_q;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      done_q <= 1'b0;
      illegal_q <= 1'b0;
      length_q <= 2'h0;
      ea_q <= OAG_WORD_RESET;
      mem_read_q <= 1'b0;
      mem_write_q <= 1'b0;
      use_index_q <= 1'b0;
      imm_valid_q <= 1'b0;
      imm_q <= OAG_BYTE_RESET;
      taken_q <= 1'b0;
      pc_next_q <= OAG_WORD_RESET;
    end
    else
    begin
      done_q <= i_start;
      mem_read_q <= i_start && mem_read_d;
      mem_write_q <= i_start && mem_write_d;
      imm_valid_q <= i_start && imm_valid_d;
      taken_q <= i_start && taken_d;
      if (i_start)
      begin
        illegal_q <= !legal;
        length_q <= length_d;
        ea_q <= ea_d;
        use_index_q <= use_index_d;
        imm_q <= i_byte1;
        pc_next_q <= pc_next_d;
      end
    end
  end

  oag_multiplier #(.WIDTH(8)) u_mul (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(i_start && is_mul && (i_mode == OAG_MODE_INHERENT)),
    .i_acc(i_acc),
    .i_index(i_index),
    .o_done(o_mul_done),
    .o_high(o_mul_index),
    .o_low(o_mul_acc)
  );

  assign o_done = done_q;
  assign o_illegal = illegal_q;
  assign o_length = length_q;
  assign o_ea = ea_q;
  assign o_mem_read = mem_read_q;
  assign o_mem_write = mem_write_q;
  assign o_use_index = use_index_q;
  assign o_imm_valid = imm_valid_q;
  assign o_imm_data = imm_q;
  assign o_branch_taken = taken_q;
  assign o_pc_next = pc_next_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_long_index;
    i_start && (i_mode == OAG_MODE_INDEX_OFFSET16);
  endsequence

  AST_IX16_ADDR: assert property (s_long_index |=>
    o_ea == 16'({$past(i_byte1), $past(i_byte2)} + {8'h00, $past(i_index)}))
    else $error("sixteen-bit indexed address wrong");
  AST_IX16_LEN: assert property (s_long_index |=> o_done && o_length == 2'h3)
    else $error("sixteen-bit indexed length not three");
  AST_IX16_MODIFY_ILLEGAL: assert property ((s_long_index and is_modify) |=> o_illegal)
    else $error("modify op accepted with sixteen-bit offset");
  AST_IX8_ALL_LEGAL: assert property (i_start && (i_mode == OAG_MODE_INDEX_OFFSET8) &&
    (is_modify || is_regmem) |=> !o_illegal && o_ea <= 16'h01FE)
    else $error("eight-bit indexed form refused or out of range");
  AST_REL_ONLY_BRANCH: assert property (i_start && (i_mode == OAG_MODE_RELATIVE) &&
    !is_branch |=> o_illegal && !o_branch_taken)
    else $error("relative mode accepted for non-branch");
  AST_NOT_TAKEN: assert property (i_start && (i_op == OAG_BRANCH_CONDITIONAL) &&
    (i_cond == OAG_COND_NEVER) && (i_mode == OAG_MODE_RELATIVE) |=> !o_branch_taken &&
    o_pc_next == 16'($past(i_pc) + 16'h0002))
    else $error("never-branch changed flow");
  AST_TAKEN_TARGET: assert property (i_start && (i_op == OAG_BRANCH_TO_SUBROUTINE) &&
    (i_mode == OAG_MODE_RELATIVE) |=> o_branch_taken && o_pc_next ==
    16'($past(i_pc) + 16'h0002 + {{8{$past(i_byte1[7])}}, $past(i_byte1)}))
    else $error("branch target wrong");
  AST_IX0_PAGE: assert property (i_start && (i_mode == OAG_MODE_INDEX_NO_OFFSET) |=>
    o_ea[15:8] == 8'h00 && o_ea[7:0] == $past(i_index) && o_length == 2'h1)
    else $error("no-offset indexed address wrong");
  AST_STORE_WRITE: assert property (i_start && is_store && (i_mode == OAG_MODE_EXTENDED)
    |=> o_mem_write && !o_mem_read ##1 !o_mem_write)
    else $error("store did not write once");
endmodule

// ### src/oag_pkg.sv
/*
  Package for the operand address generator: operation, addressing mode
  and branch condition codes, instruction lengths and reset values.
  Assumes a single core clock and a synchronous active-high reset.
*/
package oag_pkg;

  typedef enum logic [4:0] {
    OAG_LOAD_ACCUMULATOR = 5'h00,
    OAG_LOAD_INDEX = 5'h01,
    OAG_STORE_ACCUMULATOR = 5'h02,
    OAG_STORE_INDEX = 5'h03,
    OAG_ADD = 5'h04,
    OAG_ADD_WITH_CARRY = 5'h05,
    OAG_SUBTRACT = 5'h06,
    OAG_SUBTRACT_WITH_BORROW = 5'h07,
    OAG_AND_OP = 5'h08,
    OAG_INCLUSIVE_OR_OP = 5'h09,
    OAG_EXCLUSIVE_OR_OP = 5'h0A,
    OAG_COMPARE_ACCUMULATOR = 5'h0B,
    OAG_COMPARE_INDEX = 5'h0C,
    OAG_BIT_TEST = 5'h0D,
    OAG_UNSIGNED_MULTIPLY = 5'h0E,
    OAG_JUMP_UNCONDITIONAL = 5'h0F,
    OAG_JUMP_TO_SUBROUTINE = 5'h10,
    OAG_SHIFT_LEFT = 5'h11,
    OAG_SHIFT_RIGHT_ARITH = 5'h12,
    OAG_SHIFT_RIGHT_LOGIC = 5'h13,
    OAG_ROTATE_LEFT = 5'h14,
    OAG_ROTATE_RIGHT = 5'h15,
    OAG_CLEAR_OP = 5'h16,
    OAG_COMPLEMENT_OP = 5'h17,
    OAG_INCREMENT_OP = 5'h18,
    OAG_DECREMENT_OP = 5'h19,
    OAG_NEGATE_OP = 5'h1A,
    OAG_TEST_NEGATIVE_ZERO = 5'h1B,
    OAG_BRANCH_CONDITIONAL = 5'h1C,
    OAG_BRANCH_TO_SUBROUTINE = 5'h1D,
    OAG_BRANCH_IF_MEMORY_BIT_SET = 5'h1E,
    OAG_BRANCH_IF_MEMORY_BIT_CLEAR = 5'h1F
  } oag_op_t;

  typedef enum logic [2:0] {
    OAG_MODE_INHERENT = 3'h0,
    OAG_MODE_IMMEDIATE = 3'h1,
    OAG_MODE_DIRECT = 3'h2,
    OAG_MODE_EXTENDED = 3'h3,
    OAG_MODE_INDEX_NO_OFFSET = 3'h4,
    OAG_MODE_INDEX_OFFSET8 = 3'h5,
    OAG_MODE_INDEX_OFFSET16 = 3'h6,
    OAG_MODE_RELATIVE = 3'h7
  } oag_mode_t;

  typedef enum logic [3:0] {
    OAG_COND_ALWAYS = 4'h0,
    OAG_COND_NEVER = 4'h1,
    OAG_COND_HIGHER = 4'h2,
    OAG_COND_LOWER_OR_SAME = 4'h3,
    OAG_COND_CARRY_CLEAR = 4'h4,
    OAG_COND_CARRY_SET = 4'h5,
    OAG_COND_NOT_EQUAL = 4'h6,
    OAG_COND_EQUAL = 4'h7,
    OAG_COND_HALF_CARRY_CLEAR = 4'h8,
    OAG_COND_HALF_CARRY_SET = 4'h9,
    OAG_COND_PLUS = 4'hA,
    OAG_COND_MINUS = 4'hB,
    OAG_COND_MASK_CLEAR = 4'hC,
    OAG_COND_MASK_SET = 4'hD,
    OAG_COND_IRQ_LINE_LOW = 4'hE,
    OAG_COND_IRQ_LINE_HIGH = 4'hF
  } oag_cond_t;

  localparam logic [1:0] OAG_LEN_ONE = 2'h1;
  localparam logic [1:0] OAG_LEN_TWO = 2'h2;
  localparam logic [1:0] OAG_LEN_THREE = 2'h3;
  localparam logic [7:0] OAG_PAGE_ZERO_HIGH = 8'h00;
  localparam logic [7:0] OAG_BYTE_RESET = 8'h00;
  localparam logic [15:0] OAG_WORD_RESET = 16'h0000;

endpackage

// ### src/oag_multiplier.sv
/*
  Registered 8x8 unsigned multiplier: high byte for the index register,
  low byte for the accumulator.
  Assumes operands are stable in the cycle of the start pulse.
*/
`timescale 1ns/100ps
module oag_multiplier
  import oag_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [WIDTH-1:0] i_acc,
  input wire logic [WIDTH-1:0] i_index,
  output logic o_done,
  output logic [WIDTH-1:0] o_high,
  output logic [WIDTH-1:0] o_low
);
  wire logic [2*WIDTH-1:0] product_d;
  logic [2*WIDTH-1:0] product_q;
  logic done_q;

  assign product_d = i_acc * i_index;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      product_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= i_start;
      if (i_start)
        product_q <= product_d;
    end
  end

  assign o_done = done_q;
  assign o_high = product_q[2*WIDTH-1:WIDTH];
  assign o_low = product_q[WIDTH-1:0];

  AST_MUL_PRODUCT: assert property (@(posedge i_clk) disable iff (i_rst)
    i_start |=> o_done && ({o_high, o_low} == (2*WIDTH)'($past(i_acc) * $past(i_index))))
    else $error("multiply product not split into high and low bytes");
endmodule

// ### testbench/oag_prog_mem.sv
/*
  Program memory model: holds the instruction bytes and returns the two
  bytes that follow the opcode at the given address.
  Assumes the bench loads both bytes one clock before the decode request.
*/
`timescale 1ns/100ps
module oag_prog_mem
(
  input wire logic i_clk,
  input wire logic i_wr,
  input wire logic [15:0] i_wr_addr,
  input wire logic [15:0] i_wr_word,
  input wire logic [15:0] i_addr,
  output logic [7:0] o_byte1,
  output logic [7:0] o_byte2
);
  logic [7:0] mem_q [0:65535];
  logic [15:0] a1;
  logic [15:0] a2;
  assign a1 = i_addr + 16'h0001;
  assign a2 = i_addr + 16'h0002;
  // High half after the opcode, low half next
  assign o_byte1 = mem_q[a1];
  assign o_byte2 = mem_q[a2];
  always_ff @(posedge i_clk)
  begin
    if (i_wr)
    begin
      mem_q[i_wr_addr + 16'h0001] <= i_wr_word[15:8];
      mem_q[i_wr_addr + 16'h0002] <= i_wr_word[7:0];
    end
  end
endmodule

// ### testbench/tb_oag_top.sv
/*
  Self-checking bench for the operand address generator.
  Assumes registered outputs one cycle after a start pulse.
*/
`timescale 1ns/100ps
module tb_oag_top;
  import oag_pkg::*;
  logic i_clk, i_rst, start, wr, fc, fz, fh, fn, fm, mbit, irq;
  oag_op_t op;
  oag_mode_t mode;
  oag_cond_t cond;
  logic [15:0] pc, wa, ww, ea, pcn;
  logic [7:0] acc, idx, b1, b2, imd, mac, mix;
  logic [1:0] len;
  logic done, ill, mrd, mwr, uix, imv, bt, mdn;
  int fails, tests_run;

  oag_prog_mem u_mem (.i_clk(i_clk), .i_wr(wr), .i_wr_addr(wa), .i_wr_word(ww),
    .i_addr(pc), .o_byte1(b1), .o_byte2(b2));
  oag_top DUT (.i_clk(i_clk), .i_rst(i_rst), .i_start(start), .i_op(op), .i_mode(mode),
    .i_cond(cond), .i_byte1(b1), .i_byte2(b2), .i_pc(pc), .i_acc(acc), .i_index(idx),
    .i_flag_carry(fc), .i_flag_zero(fz), .i_flag_half(fh), .i_flag_negative(fn),
    .i_flag_mask(fm), .i_mem_bit(mbit), .i_irq_pin(irq), .o_done(done),
    .o_illegal(ill), .o_length(len), .o_ea(ea), .o_mem_read(mrd), .o_mem_write(mwr),
    .o_use_index(uix), .o_imm_valid(imv), .o_imm_data(imd), .o_branch_taken(bt),
    .o_pc_next(pcn), .o_mul_done(mdn), .o_mul_acc(mac), .o_mul_index(mix));

  initial
  begin
    i_clk = 0;
    forever #5 i_clk = ~i_clk;
  end

  task complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask

  task issue(input oag_op_t o, input oag_mode_t m, input oag_cond_t c,
    input logic [15:0] p, input logic [7:0] x1, input logic [7:0] x2);
    @(posedge i_clk);
    #1 wr = 1;
    wa = p;
    ww = {x1, x2};
    @(posedge i_clk);
    #1 wr = 0;
    op = o;
    mode = m;
    cond = c;
    pc = p;
    start = 1;
    @(posedge i_clk);
    #1 start = 0;
    chk("done", 16'h0001, done);
  endtask

  task t_index();
    idx = 8'h20;
    issue(OAG_LOAD_ACCUMULATOR, OAG_MODE_INDEX_OFFSET16, OAG_COND_ALWAYS, 16'h0200, 8'h12, 8'hF0);
    chk("ea16", 16'h1310, ea);
    chk("len16", 16'h0003, len);
    chk("pc16", 16'h0203, pcn);
    chk("rd16", 16'h0001, mrd);
    idx = 8'h02;
    issue(OAG_ADD, OAG_MODE_INDEX_OFFSET16, OAG_COND_ALWAYS, 16'h0300, 8'hFF, 8'hFF);
    chk("wrap", 16'h0001, ea);
    idx = 8'h80;
    issue(OAG_LOAD_ACCUMULATOR, OAG_MODE_INDEX_NO_OFFSET, OAG_COND_ALWAYS, 16'h0400, 8'h55, 8'h66);
    chk("ea0", 16'h0080, ea);
    chk("len0", 16'h0001, len);
    idx = 8'hFF;
    issue(OAG_LOAD_ACCUMULATOR, OAG_MODE_INDEX_OFFSET8, OAG_COND_ALWAYS, 16'h0500, 8'hFF, 8'h00);
    chk("ea8", 16'h01FE, ea);
    chk("len8", 16'h0002, len);
  endtask

  task t_legal();
    logic e;
    for (int o = 0; o < 28; o++)
    begin
      if (o == 14)
        continue;
      for (int m = 4; m < 8; m++)
      begin
        e = (m == 7) || (m == 6 && o >= 17);
        issue(oag_op_t'(o), oag_mode_t'(m), OAG_COND_ALWAYS, 16'h0600, 8'h10, 8'h20);
        chk("illegal", {15'h0, e}, ill);
      end
    end
  endtask

  task t_regmem();
    logic e;
    logic ux;
    for (int o = 0; o < 14; o++)
    begin
      for (int m = 1; m < 4; m++)
      begin
        e = (m == 1) && (o == 2 || o == 3);
        ux = (o == 1 || o == 3 || o == 12);
        issue(oag_op_t'(o), oag_mode_t'(m), OAG_COND_ALWAYS, 16'h0700, 8'h30 + o[7:0], 8'h44);
        chk("illegal", {15'h0, e}, ill);
        chk("use_index", {15'h0, ux}, uix);
        chk("length", (m == 3) ? 16'h0003 : 16'h0002, len);
        if (m == 1 && !e)
        begin
          chk("imm_valid", 16'h0001, imv);
          chk("imm_data", {8'h00, 8'h30 + o[7:0]}, imd);
        end
        if (m == 3)
        begin
          chk("ea_ext", {8'h30 + o[7:0], 8'h44}, ea);
          chk("write", {15'h0, o == 2 || o == 3}, mwr);
        end
      end
    end
  endtask

  task t_branch();
    logic t;
    for (int c = 0; c < 16; c++)
    begin
      t = ~c[0];
      issue(OAG_BRANCH_CONDITIONAL, OAG_MODE_RELATIVE, oag_cond_t'(c), 16'h1000, 8'h80, 8'h00);
      chk("taken", {15'h0, t}, bt);
      chk("pc_next", t ? 16'h0F82 : 16'h1002, pcn);
    end
    {fc, fz, fh, fn, fm, irq} = 6'h3F;
    repeat (4) @(posedge i_clk);
    for (int c = 0; c < 16; c++)
    begin
      t = (c < 2) ? ~c[0] : c[0];
      issue(OAG_BRANCH_CONDITIONAL, OAG_MODE_RELATIVE, oag_cond_t'(c), 16'h1000, 8'h7F, 8'h00);
      chk("taken", {15'h0, t}, bt);
      chk("pc_next", t ? 16'h1081 : 16'h1002, pcn);
    end
    for (int k = 0; k < 4; k++)
    begin
      mbit = k[1];
      t = k[0] ^ k[1];
      issue(k[0] ? OAG_BRANCH_IF_MEMORY_BIT_CLEAR : OAG_BRANCH_IF_MEMORY_BIT_SET,
        OAG_MODE_RELATIVE, OAG_COND_ALWAYS, 16'h2000, 8'h40, 8'h10);
      chk("bit_taken", {15'h0, t}, bt);
      chk("bit_ea", 16'h0040, ea);
      chk("bit_pc", t ? 16'h2013 : 16'h2003, pcn);
    end
    issue(OAG_BRANCH_TO_SUBROUTINE, OAG_MODE_RELATIVE, OAG_COND_NEVER, 16'h3000, 8'hF0, 8'h00);
    chk("bsr_pc", 16'h2FF2, pcn);
  endtask

  task t_mul();
    acc = 8'h10;
    idx = 8'h10;
    issue(OAG_UNSIGNED_MULTIPLY, OAG_MODE_INHERENT, OAG_COND_ALWAYS, 16'h4000, 8'h00, 8'h00);
    chk("mul_done", 16'h0001, mdn);
    chk("product", 16'h0100, {mix, mac});
    acc = 8'hFF;
    idx = 8'hFF;
    issue(OAG_UNSIGNED_MULTIPLY, OAG_MODE_INHERENT, OAG_COND_ALWAYS, 16'h4000, 8'h00, 8'h00);
    chk("product", 16'hFE01, {mix, mac});
    issue(OAG_UNSIGNED_MULTIPLY, OAG_MODE_DIRECT, OAG_COND_ALWAYS, 16'h4000, 8'h00, 8'h00);
    chk("mul_dir", 16'h0001, ill);
  endtask

  initial
  begin
    #200000;
    fails++;
    complete_run();
  end

  initial
  begin
    fails = 0;
    tests_run = 0;
    i_rst = 1;
    {start, wr, fc, fz, fh, fn, fm, mbit, irq} = 9'h000;
    op = OAG_LOAD_ACCUMULATOR;
    mode = OAG_MODE_INHERENT;
    cond = OAG_COND_ALWAYS;
    {pc, wa, ww} = 48'h0;
    {acc, idx} = 16'h0;
    repeat (4) @(posedge i_clk);
    #1 i_rst = 0;
    chk("rst_done", 16'h0000, done);
    chk("rst_ea", 16'h0000, ea);
    t_index();
    t_legal();
    t_regmem();
    t_branch();
    t_mul();
    complete_run();
  end
endmodule
